// ---- verilog/line_energy_power_control.sv ----
// Energy-detect power manager: event counting, thresholds, power sequencing, control register.
// Assumes line events arrive synchronous to clk_in from the analog detectors.
`timescale 1ns/1ps

module line_energy_power_control
  import energy_pkg::*;
#(
  parameter longint unsigned IDLE_CYCLES = IDLE_RESET_CYCLES,
  parameter int unsigned SEQ_CYCLES = POWER_SEQ_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic data_event_in,
  input wire logic error_event_in,
  input wire logic energy_present_in,
  output logic powered_up_out,
  output logic data_pulse_out,
  output logic irq_out
);

  line_events_t ev;
  reg_req_t req;
  assign ev = '{data_event: data_event_in, error_event: error_event_in,
                energy_present: energy_present_in};
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] a);
    hit = r.addr == a;
  endfunction

  logic enable_reg;
  logic auto_up_reg;
  logic auto_down_reg;
  logic manual_reg;
  logic burst_dis_reg;
  logic err_met_reg;
  logic data_met_reg;
  logic [THR_W-1:0] err_thr_reg;
  logic [THR_W-1:0] data_thr_reg;
  logic [THR_W-1:0] data_cnt_reg;
  logic [THR_W-1:0] err_cnt_reg;
  logic [63:0] idle_cnt_reg;
  power_state_t state_reg;
  logic [15:0] seq_cnt_reg;
  logic [2:0] pulses_reg;
  logic pulse_phase_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;

  logic ctrl_wr;
  logic ctrl_rd;
  logic data_reached;
  logic err_reached;
  logic start_up;
  logic start_down;
  logic manual_start;
  logic idle_expire;
  logic [DATA_W-1:0] ctrl_view;
  logic [IRQ_W-1:0] irq_events;

  assign ctrl_wr = req.wr && hit(req, ADDR_CONTROL);
  assign ctrl_rd = req.rd && hit(req, ADDR_CONTROL);
  assign data_reached = data_cnt_reg >= data_thr_reg;
  assign err_reached = err_cnt_reg >= err_thr_reg;
  assign idle_expire = idle_cnt_reg == IDLE_CYCLES - 64'h1;
  // Manual request takes effect only in a settled state, so it is held through a sequence unless enable is cleared.
  assign manual_start = enable_reg && manual_reg
                        && (state_reg == PWR_UP || state_reg == PWR_DOWN);
  assign start_up = enable_reg && state_reg == PWR_DOWN
                    && (manual_start || (auto_up_reg && data_reached));
  assign start_down = enable_reg && state_reg == PWR_UP
                      && (manual_start || (auto_down_reg && !ev.energy_present));

  always_comb begin
    ctrl_view = '0;
    ctrl_view[BIT_ENABLE] = enable_reg;
    ctrl_view[BIT_AUTO_UP] = auto_up_reg;
    ctrl_view[BIT_AUTO_DOWN] = auto_down_reg;
    ctrl_view[BIT_MANUAL] = manual_reg;
    ctrl_view[BIT_BURST_DIS] = burst_dis_reg;
    ctrl_view[BIT_PWR_STATE] = state_reg == PWR_UP || state_reg == PWR_FALLING;
    ctrl_view[BIT_ERR_MET] = err_met_reg;
    ctrl_view[BIT_DATA_MET] = data_met_reg;
    ctrl_view[ERR_THR_LSB +: THR_W] = err_thr_reg;
    ctrl_view[DATA_THR_LSB +: THR_W] = data_thr_reg;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enable_reg <= 1'b0;
      auto_up_reg <= 1'b1;
      auto_down_reg <= 1'b1;
      burst_dis_reg <= 1'b0;
      err_thr_reg <= THR_RESET;
      data_thr_reg <= THR_RESET;
    end else if (ctrl_wr) begin
      enable_reg <= req.wdata[BIT_ENABLE];
      auto_up_reg <= req.wdata[BIT_AUTO_UP];
      auto_down_reg <= req.wdata[BIT_AUTO_DOWN];
      burst_dis_reg <= req.wdata[BIT_BURST_DIS];
      err_thr_reg <= req.wdata[ERR_THR_LSB +: THR_W];
      data_thr_reg <= req.wdata[DATA_THR_LSB +: THR_W];
    end
  end

  // A fresh write of one wins over the self-clear of an older request.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      manual_reg <= 1'b0;
    end else if (ctrl_wr && req.wdata[BIT_MANUAL]) begin
      manual_reg <= 1'b1;
    end else if (manual_start || !enable_reg) begin
      manual_reg <= 1'b0;
    end
  end

  // Data and error counters saturate so a burst of noise cannot wrap them back below threshold.
  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_reg) begin
      data_cnt_reg <= '0;
      err_cnt_reg <= '0;
      idle_cnt_reg <= '0;
    end else begin
      // The quiet timer re-arms at each expiry, so error events after a long quiet spell count.
      if (ev.data_event || idle_expire) begin
        idle_cnt_reg <= '0;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 64'h1;
      end
      if (idle_expire && !ev.data_event) begin
        data_cnt_reg <= '0;
        err_cnt_reg <= '0;
      end else begin
        if (start_up) begin
          data_cnt_reg <= '0;
        end else if (ev.data_event && data_cnt_reg != '1) begin
          data_cnt_reg <= data_cnt_reg + 4'h1;
        end
        if (ev.error_event && err_cnt_reg != '1) begin
          err_cnt_reg <= err_cnt_reg + 4'h1;
        end
      end
    end
  end

  // Met flags: a new hit in the read cycle wins over the clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      err_met_reg <= 1'b0;
      data_met_reg <= 1'b0;
    end else begin
      if (enable_reg && err_reached && err_cnt_reg != '0) begin
        err_met_reg <= 1'b1;
      end else if (ctrl_rd) begin
        err_met_reg <= 1'b0;
      end
      if (enable_reg && data_reached && data_cnt_reg != '0) begin
        data_met_reg <= 1'b1;
      end else if (ctrl_rd) begin
        data_met_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= PWR_DOWN;
      seq_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        PWR_DOWN: begin
          if (start_up) begin
            state_reg <= PWR_RISING;
            seq_cnt_reg <= '0;
          end
        end
        PWR_RISING: begin
          if (seq_cnt_reg == 16'(SEQ_CYCLES - 1)) begin
            state_reg <= PWR_UP;
          end else begin
            seq_cnt_reg <= seq_cnt_reg + 16'h1;
          end
        end
        PWR_UP: begin
          if (start_down) begin
            state_reg <= PWR_FALLING;
            seq_cnt_reg <= '0;
          end
        end
        PWR_FALLING: begin
          if (seq_cnt_reg == 16'(SEQ_CYCLES - 1)) begin
            state_reg <= PWR_DOWN;
          end else begin
            seq_cnt_reg <= seq_cnt_reg + 16'h1;
          end
        end
      endcase
    end
  end

  // Pulses go out every other cycle so each one is a separate edge on the line.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulses_reg <= '0;
      pulse_phase_reg <= 1'b0;
      data_pulse_out <= 1'b0;
    end else if (start_up) begin
      pulses_reg <= burst_dis_reg ? SINGLE_PULSE : BURST_PULSES;
      pulse_phase_reg <= 1'b0;
      data_pulse_out <= 1'b0;
    end else if (pulses_reg != '0 && !pulse_phase_reg) begin
      data_pulse_out <= 1'b1;
      pulse_phase_reg <= 1'b1;
      pulses_reg <= pulses_reg - 3'h1;
    end else begin
      data_pulse_out <= 1'b0;
      pulse_phase_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      powered_up_out <= 1'b0;
    end else begin
      powered_up_out <= state_reg == PWR_UP || state_reg == PWR_FALLING;
    end
  end

  assign irq_events[IRQ_POWER_UP] = state_reg == PWR_RISING
                                    && seq_cnt_reg == 16'(SEQ_CYCLES - 1);
  assign irq_events[IRQ_POWER_DOWN] = state_reg == PWR_FALLING
                                      && seq_cnt_reg == 16'(SEQ_CYCLES - 1);
  assign irq_events[IRQ_DATA_MET] = enable_reg && data_reached && data_cnt_reg != '0
                                    && !data_met_reg;
  assign irq_events[IRQ_ERR_MET] = enable_reg && err_reached && err_cnt_reg != '0
                                   && !err_met_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_status_reg <= irq_events | (irq_status_reg
                        & ~((req.wr && hit(req, ADDR_IRQ_CLEAR)) ? req.wdata[IRQ_W-1:0] : '0));
      if (req.wr && hit(req, ADDR_IRQ_ENABLE)) begin
        irq_enable_reg <= req.wdata[IRQ_W-1:0];
      end
      irq_out <= |(irq_status_reg & irq_enable_reg);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (req.rd) begin
      if (hit(req, ADDR_CONTROL)) begin
        rdata_out <= ctrl_view;
      end else if (hit(req, ADDR_IRQ_STATUS)) begin
        rdata_out <= DATA_W'(irq_status_reg);
      end else if (hit(req, ADDR_IRQ_ENABLE)) begin
        rdata_out <= DATA_W'(irq_enable_reg);
      end else begin
        rdata_out <= '0;
      end
    end else begin
      rdata_out <= '0;
    end
  end

  AST_RESET_OFF: assert property (@(posedge clk_in) rst_in |=> !enable_reg)
    else $error("Enable bit not cleared by reset.");

  AST_NO_START_DISABLED: assert property (@(posedge clk_in) disable iff (rst_in)
    !enable_reg && state_reg == PWR_DOWN |=> state_reg == PWR_DOWN)
    else $error("Power state moved while mode disabled.");

  AST_AUTO_UP: assert property (@(posedge clk_in) disable iff (rst_in)
    enable_reg && auto_up_reg && state_reg == PWR_DOWN && data_reached
    |=> state_reg == PWR_RISING)
    else $error("Auto power-up did not start at threshold.");

  AST_AUTO_DOWN: assert property (@(posedge clk_in) disable iff (rst_in)
    enable_reg && auto_down_reg && state_reg == PWR_UP && !ev.energy_present
    |=> state_reg == PWR_FALLING)
    else $error("Auto power-down did not start without energy.");

  AST_MANUAL: assert property (@(posedge clk_in) disable iff (rst_in)
    manual_start |=> state_reg == PWR_RISING || state_reg == PWR_FALLING)
    else $error("Manual toggle did not change power state.");

  AST_MANUAL_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    manual_start && !ctrl_wr |=> !manual_reg)
    else $error("Manual bit did not self-clear.");

  sequence burst_four_s;
    data_pulse_out ##2 data_pulse_out ##2 data_pulse_out ##2 data_pulse_out;
  endsequence

  AST_BURST: assert property (@(posedge clk_in) disable iff (rst_in)
    start_up && !burst_dis_reg ##1 !start_up |=> burst_four_s)
    else $error("Power-up burst was not four pulses.");

  AST_SINGLE: assert property (@(posedge clk_in) disable iff (rst_in)
    start_up && burst_dis_reg ##1 !start_up |=> data_pulse_out ##1 !data_pulse_out [*4])
    else $error("Burst-disabled power-up did not send one pulse.");

  AST_POWER_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 powered_up_out == $past(ctrl_view[BIT_PWR_STATE]))
    else $error("Power flag output mismatch.");

  AST_DATA_MET_COR: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_rd && !(enable_reg && data_reached && data_cnt_reg != '0) |=> !data_met_reg)
    else $error("Data met flag not cleared on read.");

  AST_ERR_MET_SET: assert property (@(posedge clk_in) disable iff (rst_in)
    enable_reg && err_reached && err_cnt_reg != '0 |=> err_met_reg)
    else $error("Error met flag not set at threshold.");

  AST_IDLE_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    enable_reg && idle_expire && !ev.data_event |=> data_cnt_reg == '0 && err_cnt_reg == '0)
    else $error("Counters not cleared after idle time.");

endmodule

// ---- verilog/energy_pkg.sv ----
// Package for the line energy power control block: register map, field layout, timing.
// Assumes a single 250 MHz clock and a plain one-cycle register port.
package energy_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 5'h1d;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 5'h1e;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 5'h1f;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 5'h1c;
  localparam int unsigned BIT_ENABLE = 15;
  localparam int unsigned BIT_AUTO_UP = 14;
  localparam int unsigned BIT_AUTO_DOWN = 13;
  localparam int unsigned BIT_MANUAL = 12;
  localparam int unsigned BIT_BURST_DIS = 11;
  localparam int unsigned BIT_PWR_STATE = 10;
  localparam int unsigned BIT_ERR_MET = 9;
  localparam int unsigned BIT_DATA_MET = 8;
  localparam int unsigned ERR_THR_LSB = 4;
  localparam int unsigned DATA_THR_LSB = 0;
  localparam int unsigned THR_W = 4;
  localparam logic [THR_W-1:0] THR_RESET = 4'h1;
  localparam logic [2:0] BURST_PULSES = 3'h4;
  localparam logic [2:0] SINGLE_PULSE = 3'h1;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_POWER_UP = 0;
  localparam int unsigned IRQ_POWER_DOWN = 1;
  localparam int unsigned IRQ_DATA_MET = 2;
  localparam int unsigned IRQ_ERR_MET = 3;
  localparam longint unsigned CLK_HZ = 250000000;
  localparam longint unsigned IDLE_RESET_MS = 2000;
  localparam longint unsigned IDLE_RESET_CYCLES = (CLK_HZ / 1000) * IDLE_RESET_MS;
  localparam int unsigned POWER_SEQ_CYCLES = 8;

  typedef enum logic [1:0] {
    PWR_DOWN = 2'b00,
    PWR_RISING = 2'b01,
    PWR_UP = 2'b11,
    PWR_FALLING = 2'b10
  } power_state_t;

  typedef struct packed {
    logic data_event;
    logic error_event;
    logic energy_present;
  } line_events_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ---- test/link_partner_model.sv ----
// Remote link partner model: line energy level and detector event pulses.
// Assumes the bench asks for a burst with a one-cycle go pulse.
`timescale 1ns/1ps
module link_partner_model
  import energy_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [3:0] len_in,
  input wire logic err_in,
  input wire logic energy_on_in,
  output logic busy_out,
  output line_events_t line_out
);
  logic [3:0] left_reg;
  logic kind_reg;
  logic gap_reg;
  assign busy_out = (left_reg != 4'h0);
  // A gap cycle between events keeps every pulse a separate detection.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      left_reg <= 4'h0;
      kind_reg <= 1'b0;
      gap_reg <= 1'b0;
      line_out <= '0;
    end else begin
      line_out.energy_present <= energy_on_in;
      line_out.data_event <= busy_out && !gap_reg && !kind_reg;
      line_out.error_event <= busy_out && !gap_reg && kind_reg;
      gap_reg <= busy_out && !gap_reg;
      if (go_in) begin
        left_reg <= len_in;
        kind_reg <= err_in;
      end else if (busy_out && gap_reg) begin
        left_reg <= left_reg - 4'h1;
      end
    end
  end
endmodule

// ---- test/line_energy_power_control_tb_top.sv ----
// Self-checking bench for the line energy power control block.
// Assumes the partner model in its own file and the design package.
`timescale 1ns/1ps
module line_energy_power_control_tb_top;
  import energy_pkg::*;
  localparam int IDLE = 40;
  logic clk_in, rst_in, wr_in, rd_in, go, err, en_on, busy;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in, rdata_out, d;
  logic powered_up_out, data_pulse_out, irq_out;
  logic [3:0] len, thr;
  line_events_t line;
  int n_errors, num_checks, pulses;

  line_energy_power_control #(.IDLE_CYCLES(IDLE), .SEQ_CYCLES(8))
    line_energy_power_control_inst (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .data_event_in(line.data_event), .error_event_in(line.error_event),
    .energy_present_in(line.energy_present), .powered_up_out(powered_up_out),
    .data_pulse_out(data_pulse_out), .irq_out(irq_out));
  link_partner_model link_partner_model_inst (.clk_in(clk_in), .rst_in(rst_in),
    .go_in(go), .len_in(len), .err_in(err), .energy_on_in(en_on), .busy_out(busy),
    .line_out(line));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (data_pulse_out === 1'b1) pulses++;

  function automatic logic [15:0] ctrl_exp(input logic [2:0] mode, input logic bd, pwr,
    input logic em, dm, input logic [3:0] et, dt);
    return {mode, 1'b0, bd, pwr, em, dm, et, dt};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic send(input logic [3:0] n, input logic e);
    int i;
    @(posedge clk_in);
    go <= 1'b1;
    len <= n;
    err <= e;
    @(posedge clk_in);
    go <= 1'b0;
    #1;
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
  endtask
  task automatic wait_pu(input logic v);
    int i;
    for (i = 0; i < 60 && powered_up_out !== v; i++) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
    check("powered_up_out", powered_up_out, v);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #40000;
    n_errors++;
    summarize();
  end

  initial begin
    {wr_in, rd_in, go, err, en_on, len, addr_in, wdata_in} = '0;
    n_errors = 0;
    num_checks = 0;
    pulses = 0;
    void'($urandom(63599));
    thr = 4'h1 + 4'($urandom_range(3));
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(ADDR_CONTROL);
    check("ctrl_reset", d, 16'h6011);
    check("ctrl_reset_thr", d, ctrl_exp(3'h3, 0, 0, 0, 0, 4'h1, 4'h1));
    wr(ADDR_CONTROL, 16'h6711);
    wr(5'h03, 16'hffff);
    rd(5'h03);
    check("unmapped", d, 16'h0000);
    rd(ADDR_CONTROL);
    check("ro_bits", d, 16'h6011);
    // Events while the mode is off must not power anything up.
    send(4'h3, 1'b0);
    repeat (10) @(posedge clk_in);
    check("disabled", powered_up_out, 1'b0);
    en_on <= 1'b1;
    // Crossover lives outside this block and is taken as already off while the mode runs.
    wr(ADDR_CONTROL, ctrl_exp(3'h7, 0, 0, 0, 0, 4'h2, thr));
    send(thr - 4'h1, 1'b0);
    check("below_thr", powered_up_out, 1'b0);
    pulses = 0;
    send(4'h1, 1'b0);
    wait_pu(1'b1);
    check("burst", 16'(pulses), 16'h4);
    check("irq_masked", irq_out, 1'b0);
    rd(ADDR_CONTROL);
    check("ctrl_up", d, ctrl_exp(3'h7, 0, 1, 0, 1, 4'h2, thr));
    rd(ADDR_CONTROL);
    check("data_met_cor", d[BIT_DATA_MET], 1'b0);
    send(4'h2, 1'b1);
    rd(ADDR_CONTROL);
    check("err_met", d, ctrl_exp(3'h7, 0, 1, 1, 0, 4'h2, thr));
    en_on <= 1'b0;
    wait_pu(1'b0);
    rd(ADDR_CONTROL);
    check("pwr_down", d[BIT_PWR_STATE], 1'b0);
    // Two events split by a long quiet spell never add up to two.
    wr(ADDR_CONTROL, ctrl_exp(3'h7, 0, 0, 0, 0, 4'h2, 4'h2));
    en_on <= 1'b1;
    send(4'h1, 1'b0);
    repeat (IDLE + 10) @(posedge clk_in);
    send(4'h1, 1'b0);
    repeat (10) @(posedge clk_in);
    check("idle_clear", powered_up_out, 1'b0);
    rd(ADDR_CONTROL);
    rd(ADDR_CONTROL);
    check("err_met_cor", d, ctrl_exp(3'h7, 0, 0, 0, 0, 4'h2, 4'h2));
    wr(ADDR_IRQ_ENABLE, 16'h0001);
    wr(ADDR_IRQ_CLEAR, 16'h000f);
    pulses = 0;
    wr(ADDR_CONTROL, ctrl_exp(3'h4, 1, 0, 0, 0, 4'h2, 4'hf) | 16'h1000);
    wait_pu(1'b1);
    check("single", 16'(pulses), 16'h1);
    rd(ADDR_CONTROL);
    check("manual_sc", d[BIT_MANUAL], 1'b0);
    check("pwr_up", d[BIT_PWR_STATE], 1'b1);
    check("irq_up", irq_out, 1'b1);
    wr(ADDR_IRQ_CLEAR, 16'h0001);
    repeat (3) @(posedge clk_in);
    check("irq_clr", irq_out, 1'b0);
    wr(ADDR_IRQ_ENABLE, 16'h0000);
    wr(ADDR_CONTROL, ctrl_exp(3'h4, 1, 0, 0, 0, 4'h2, 4'hf) | 16'h1000);
    wait_pu(1'b0);
    check("irq_off", irq_out, 1'b0);
    rd(ADDR_IRQ_STATUS);
    check("sticky_down", d[IRQ_POWER_DOWN], 1'b1);
    summarize();
  end
endmodule
